// [bench/dpmu_cls_model.sv]
// Classifier front end: hands one TOS byte per request to the lookup port.
// Assumes the bench raises req just after a rising edge.
`timescale 1ns/1ns
module dpmu_cls_model (
	input  wire logic       clock,
	input  wire logic       req,
	input  wire logic [7:0] tos,
	output logic            cls_vld,
	output logic      [7:0] cls_tos
);
	logic       req_s;
	logic [7:0] tos_s;
	initial cls_vld = 1'b0;
	initial cls_tos = 8'h00;
	// Idle byte toggles so a stale codepoint never looks valid
	always @(posedge clock) begin
		req_s = req;
		tos_s = tos;
		#1;
		cls_vld = req_s;
		cls_tos = req_s ? tos_s : ~cls_tos;
	end
endmodule : dpmu_cls_model

// [bench/tb_dpmu_top.sv]
// Bench for the upper priority map: register port, lookups, resets.
// Assumes the classifier model drives the lookup port.
`timescale 1ns/1ns
module tb_dpmu_top;
	import dpmu_pkg::*;
	logic       clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
	logic       reg_rvld, cls_vld, cls_hit, cls_prio_vld;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tos = 8'h00, reg_rdata, cls_tos;
	logic [1:0] cls_prio;
	logic [7:0] tab [8];
	logic [7:0] wa;
	int         error_cnt = 0, num_checks = 0, seed = 32'h4c97, i;
	dpmu_top uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvld(reg_rvld),
		.cls_vld(cls_vld), .cls_tos(cls_tos), .cls_prio(cls_prio), .cls_hit(cls_hit),
		.cls_prio_vld(cls_prio_vld));
	dpmu_cls_model ucls (.clock(clock), .req(req), .tos(tos), .cls_vld(cls_vld),
		.cls_tos(cls_tos));
	// --------------------------------
	// Expectations and bus cycles
	// --------------------------------
	function automatic logic in_map(logic [7:0] a);
		return a[7:3] == DPMU_ADDR_HI;
	endfunction : in_map
	function automatic logic [1:0] exp_prio(logic [5:0] cp);
		return (cp < DPMU_CP_FIRST) ? DPMU_PRIO_RST : tab[cp[4:2]][2*cp[1:0] +: 2];
	endfunction : exp_prio
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic step;
		@(posedge clock);
		#1;
	endtask : step
	// Idle cycle after each strobe keeps one assignment per time step
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		step();
		reg_wr = 1'b0;
		if (in_map(a))
			tab[a[2:0]] = d;
		step();
	endtask : wr
	task automatic rd(logic [7:0] a);
		reg_addr = a;
		reg_rd   = 1'b1;
		step();
		reg_rd = 1'b0;
		chk({7'h00, reg_rvld}, {7'h00, in_map(a)});
		chk(reg_rdata, in_map(a) ? tab[a[2:0]] : DPMU_MAP_RST);
		step();
	endtask : rd
	// Write with a lookup, then a read: both see the new byte one cycle on
	task automatic wl(logic [7:0] a, logic [7:0] d, logic [7:0] t);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		tos       = t;
		req       = 1'b1;
		step();
		reg_wr = 1'b0;
		req    = 1'b0;
		reg_rd = 1'b1;
		tab[a[2:0]] = d;
		step();
		reg_rd = 1'b0;
		chk(reg_rdata, d);
		chk({6'h00, cls_prio_vld, reg_rvld}, 8'h03);
		chk({6'h00, cls_prio}, {6'h00, exp_prio(t[7:2])});
		step();
	endtask : wl
	task automatic look(logic [7:0] t);
		tos = t;
		req = 1'b1;
		step();
		req = 1'b0;
		for (int k = 0; k < 4 && cls_prio_vld !== 1'b1; k++)
			step();
		chk({6'h00, cls_prio_vld, cls_hit}, {6'h00, 1'b1, t[7]});
		chk({6'h00, cls_prio}, {6'h00, exp_prio(t[7:2])});
		step();
	endtask : look
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	initial forever #25 clock = ~clock;
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
	initial begin
		foreach (tab[k]) tab[k] = DPMU_MAP_RST;
		repeat (4) @(posedge clock);
		#1;
		rst_b = 1'b1;
		for (i = 8'h66; i < 8'h72; i++) rd(i[7:0]);
		$display("test reset values done");
		wr(8'h67, 8'hff);
		for (i = 0; i < DPMU_NREG; i++) wr(DPMU_OFS_20_23 + i[7:0], 8'($random(seed)));
		for (i = 0; i < DPMU_NREG; i++) rd(DPMU_OFS_20_23 + i[7:0]);
		for (i = 0; i < 64; i++) look({i[5:0], 2'($random(seed))});
		$display("test full table done");
		for (i = 0; i < 40; i++) begin
			wa = 8'(DPMU_OFS_20_23 + ($random(seed) & 7));
			wl(wa, 8'($random(seed)), {1'b1, wa[2:0], 4'($random(seed))});
			look({1'b1, 7'($random(seed))});
		end
		$display("test write then lookup done");
		rst_b = 1'b0;
		step();
		rst_b = 1'b1;
		foreach (tab[k]) tab[k] = DPMU_MAP_RST;
		rd(DPMU_OFS_38_3B);
		look(8'hfd);
		$display("test second reset done");
		test_done();
	end
endmodule : tb_dpmu_top

// [rtl/dpmu_pkg.sv]
// Constants for the upper DiffServ priority map: offsets, fields, reset values.
// Assumes byte-wide register access through the switch management port.
//
// What this block does
// RULE_01: Codepoint is bits 7..2 of the frame's TOS/DiffServ/Traffic Class byte.
// RULE_02: Offset 0x68 holds priorities for codepoints 0x20..0x23, two bits each.
// RULE_03: Offset 0x69 holds priorities for codepoints 0x24..0x27, two bits each.
// RULE_04: Offset 0x6A holds priorities for codepoints 0x28..0x2B, two bits each.
// RULE_05: Offset 0x6B holds priorities for codepoints 0x2C..0x2F, two bits each.
// RULE_06: Offset 0x6C holds priorities for codepoints 0x30..0x33, two bits each.
// RULE_07: Offset 0x6D holds priorities for codepoints 0x34..0x37, two bits each.
// RULE_08: Offset 0x6E holds priorities for codepoints 0x38..0x3B, two bits each.
// RULE_09: Every field is read/write and clears to zero on reset.
// RULE_10: Offset 0x6F holds codepoints 0x3C..0x3F with the same layout.
// RULE_11: Lookup reads stored fields directly; writes affect only later frames.
package dpmu_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] DPMU_OFS_20_23 = 8'h68;
	localparam logic [7:0] DPMU_OFS_24_27 = 8'h69;
	localparam logic [7:0] DPMU_OFS_28_2B = 8'h6a;
	localparam logic [7:0] DPMU_OFS_2C_2F = 8'h6b;
	localparam logic [7:0] DPMU_OFS_30_33 = 8'h6c;
	localparam logic [7:0] DPMU_OFS_34_37 = 8'h6d;
	localparam logic [7:0] DPMU_OFS_38_3B = 8'h6e;
	localparam logic [7:0] DPMU_OFS_3C_3F = 8'h6f;

	// ---------------------------------------------------------------
	// Table layout
	// ---------------------------------------------------------------
	localparam int         DPMU_NREG      = 8;
	localparam logic [4:0] DPMU_ADDR_HI   = 5'h0d;   // 0x68..0x6F share addr[7:3]
	localparam int         DPMU_CP_MSB    = 7;
	localparam int         DPMU_CP_LSB    = 2;
	localparam logic [5:0] DPMU_CP_FIRST  = 6'h20;
	localparam int         DPMU_FLD_W     = 2;
	localparam logic [7:0] DPMU_MAP_RST   = 8'h00;
	localparam logic [1:0] DPMU_PRIO_RST  = 2'h0;

endpackage : dpmu_pkg

// [rtl/dpmu_top.sv]
// Upper DiffServ priority map: eight byte registers and the classifier lookup.
// Assumes the management port and classifier run on the system clock.
`timescale 1ns/1ns

module dpmu_top
	import dpmu_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvld,
	input  wire logic       cls_vld,
	input  wire logic [7:0] cls_tos,
	output logic      [1:0] cls_prio,
	output logic            cls_hit,
	output logic            cls_prio_vld
);

	// ---------------------------------------------------------------
	// Storage and decode
	// ---------------------------------------------------------------
	logic [7:0] map_r [DPMU_NREG];
	logic [7:0] reg_rdata_r;
	logic       reg_rvld_r;
	logic [1:0] cls_prio_r;
	logic       cls_hit_r;
	logic       cls_prio_vld_r;

	wire        addr_in  = (reg_addr[7:3] == DPMU_ADDR_HI);
	wire  [2:0] addr_idx = reg_addr[2:0];
	wire        wr_hit   = reg_wr && addr_in;
	wire        rd_hit   = reg_rd && addr_in;

	// Upper half of codepoint space lives here; lower half in another bank
	wire  [5:0] cp       = cls_tos[DPMU_CP_MSB:DPMU_CP_LSB];        // RULE_01
	wire        cp_hit   = (cp >= DPMU_CP_FIRST);
	wire  [2:0] cp_reg   = cp[4:2];
	// Each register serves four codepoints; codepoint bits 4..2 pick the byte
	wire  [7:0] byte_20_23 = map_r[0];                               // RULE_02
	wire  [7:0] byte_24_27 = map_r[1];                               // RULE_03
	wire  [7:0] byte_28_2b = map_r[2];                               // RULE_04
	wire  [7:0] byte_2c_2f = map_r[3];                               // RULE_05
	wire  [7:0] byte_30_33 = map_r[4];                               // RULE_06
	wire  [7:0] byte_34_37 = map_r[5];                               // RULE_07
	wire  [7:0] byte_38_3b = map_r[6];                               // RULE_08
	wire  [7:0] byte_3c_3f = map_r[7];                               // RULE_10

	wire  [7:0] cp_byte  = (cp_reg == 3'h0) ? byte_20_23 :
	                       (cp_reg == 3'h1) ? byte_24_27 :
	                       (cp_reg == 3'h2) ? byte_28_2b :
	                       (cp_reg == 3'h3) ? byte_2c_2f :
	                       (cp_reg == 3'h4) ? byte_30_33 :
	                       (cp_reg == 3'h5) ? byte_34_37 :
	                       (cp_reg == 3'h6) ? byte_38_3b :
	                       byte_3c_3f;                                // RULE_11
	wire  [1:0] cp_fld   = cp_byte[{cp[1:0], 1'b0} +: DPMU_FLD_W];   // RULE_02
	wire  [1:0] prio_nxt = cp_hit ? cp_fld : DPMU_PRIO_RST;

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	// A read in the same cycle as a write returns the old contents
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DPMU_NREG; i++) begin
				map_r[i] <= DPMU_MAP_RST;                          // RULE_09
			end
		end else if (wr_hit) begin
			map_r[addr_idx] <= reg_wdata;                          // RULE_10
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_r <= DPMU_MAP_RST;
			reg_rvld_r  <= 1'b0;
		end else begin
			reg_rdata_r <= rd_hit ? map_r[addr_idx] : DPMU_MAP_RST;  // RULE_09
			reg_rvld_r  <= rd_hit;
		end
	end

	// ---------------------------------------------------------------
	// Lookup
	// ---------------------------------------------------------------
	// Output is registered; a write seen at this edge applies to the next frame
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cls_prio_r     <= DPMU_PRIO_RST;
			cls_hit_r      <= 1'b0;
			cls_prio_vld_r <= 1'b0;
		end else begin
			cls_prio_r     <= cls_vld ? prio_nxt : DPMU_PRIO_RST;    // RULE_03
			cls_hit_r      <= cls_vld && cp_hit;                     // RULE_01
			cls_prio_vld_r <= cls_vld;
		end
	end

	assign reg_rdata    = reg_rdata_r;
	assign reg_rvld     = reg_rvld_r;
	assign cls_prio     = cls_prio_r;
	assign cls_hit      = cls_hit_r;
	assign cls_prio_vld = cls_prio_vld_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	logic first_r;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	property p_entry(logic [5:0] base, logic [7:0] r);
		logic [1:0] v;
		@(posedge clock) disable iff (!rst_b)
		(cls_vld && ({cp[5:2], 2'b00} == base), v = r[{cp[1:0], 1'b0} +: 2]) |=>
			(cls_prio == v) && cls_hit && cls_prio_vld;
	endproperty

	sequence s_write(logic [7:0] a, logic [7:0] d);
		reg_wr && addr_in && (reg_addr == a) && (reg_wdata == d);
	endsequence

	a_cp_index: assert property (@(posedge clock) disable iff (!rst_b) // RULE_01
		cls_vld |=> (cls_hit == $past(cls_tos[7])) && cls_prio_vld)
		else $error("codepoint range decoded from wrong TOS bits");
	a_map_20: assert property (p_entry(6'h20, map_r[0])) // RULE_02
		else $error("priority for codepoints 20-23 wrong");
	a_map_24: assert property (p_entry(6'h24, map_r[1])) // RULE_03
		else $error("priority for codepoints 24-27 wrong");
	a_map_28: assert property (p_entry(6'h28, map_r[2])) // RULE_04
		else $error("priority for codepoints 28-2b wrong");
	a_map_2c: assert property (p_entry(6'h2c, map_r[3])) // RULE_05
		else $error("priority for codepoints 2c-2f wrong");
	a_map_30: assert property (p_entry(6'h30, map_r[4])) // RULE_06
		else $error("priority for codepoints 30-33 wrong");
	a_map_34: assert property (p_entry(6'h34, map_r[5])) // RULE_07
		else $error("priority for codepoints 34-37 wrong");
	a_map_38: assert property (p_entry(6'h38, map_r[6])) // RULE_08
		else $error("priority for codepoints 38-3b wrong");
	a_map_3c: assert property (p_entry(6'h3c, map_r[7])) // RULE_10
		else $error("priority for codepoints 3c-3f wrong");
	a_reset_zero: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
		first_r |-> (map_r[0] == 8'h00) && (map_r[3] == 8'h00) && (map_r[7] == 8'h00))
		else $error("table not cleared by reset");

	property p_readback;
		logic [7:0] a, d;
		@(posedge clock) disable iff (!rst_b)
		(reg_wr && addr_in, a = reg_addr, d = reg_wdata) ##1
		(reg_rd && !reg_wr && reg_addr == a) |=> reg_rvld && (reg_rdata == d);
	endproperty
	a_rw_readback: assert property (p_readback) // RULE_09
		else $error("read does not return written value");

	property p_new_prio;
		logic [7:0] a, d;
		@(posedge clock) disable iff (!rst_b)
		(s_write(reg_addr, reg_wdata), a = reg_addr, d = reg_wdata) ##1
		(cls_vld && !reg_wr && cp[5] && cp[4:2] == a[2:0]) |=>
			cls_prio == d[{$past(cp[1:0]), 1'b0} +: 2];
	endproperty
	a_write_effect: assert property (p_new_prio) // RULE_11
		else $error("frame after write did not see new priority");

	// ---------------------------------------------------------------
	// Per-register write strobes
	// ---------------------------------------------------------------
	// Read only by the checks below; the store itself indexes by addr[2:0]
	wire        wr_20_23 = wr_hit && (reg_addr == DPMU_OFS_20_23);   // RULE_02
	wire        wr_24_27 = wr_hit && (reg_addr == DPMU_OFS_24_27);   // RULE_03
	wire        wr_28_2b = wr_hit && (reg_addr == DPMU_OFS_28_2B);   // RULE_04
	wire        wr_2c_2f = wr_hit && (reg_addr == DPMU_OFS_2C_2F);   // RULE_05
	wire        wr_30_33 = wr_hit && (reg_addr == DPMU_OFS_30_33);   // RULE_06
	wire        wr_34_37 = wr_hit && (reg_addr == DPMU_OFS_34_37);   // RULE_07
	wire        wr_38_3b = wr_hit && (reg_addr == DPMU_OFS_38_3B);   // RULE_08
	wire        wr_3c_3f = wr_hit && (reg_addr == DPMU_OFS_3C_3F);   // RULE_10

	// ---------------------------------------------------------------
	// Request sequences
	// ---------------------------------------------------------------
	// Every request is answered exactly one edge later, so one step is enough
	sequence s_read_req;
		reg_rd && addr_in;
	endsequence

	sequence s_read_miss;
		!(reg_rd && addr_in);
	endsequence

	sequence s_wr_miss;
		reg_wr && !addr_in;
	endsequence

	sequence s_lookup_low;
		cls_vld && !cp[5];
	endsequence

	sequence s_lookup_high;
		cls_vld && cp[5];
	endsequence

	sequence s_lookup_idle;
		!cls_vld;
	endsequence

	// ---------------------------------------------------------------
	// Write landing
	// ---------------------------------------------------------------
	a_wr_land_20: assert property (@(posedge clock) disable iff (!rst_b) // RULE_02
		wr_20_23 |=> (map_r[0] == $past(reg_wdata)))
		else $error("write to codepoints 20-23 did not land");

	a_wr_land_24: assert property (@(posedge clock) disable iff (!rst_b) // RULE_03
		wr_24_27 |=> (map_r[1] == $past(reg_wdata)))
		else $error("write to codepoints 24-27 did not land");

	a_wr_land_28: assert property (@(posedge clock) disable iff (!rst_b) // RULE_04
		wr_28_2b |=> (map_r[2] == $past(reg_wdata)))
		else $error("write to codepoints 28-2b did not land");

	a_wr_land_2c: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
		wr_2c_2f |=> (map_r[3] == $past(reg_wdata)))
		else $error("write to codepoints 2c-2f did not land");

	a_wr_land_30: assert property (@(posedge clock) disable iff (!rst_b) // RULE_06
		wr_30_33 |=> (map_r[4] == $past(reg_wdata)))
		else $error("write to codepoints 30-33 did not land");

	a_wr_land_34: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
		wr_34_37 |=> (map_r[5] == $past(reg_wdata)))
		else $error("write to codepoints 34-37 did not land");

	a_wr_land_38: assert property (@(posedge clock) disable iff (!rst_b) // RULE_08
		wr_38_3b |=> (map_r[6] == $past(reg_wdata)))
		else $error("write to codepoints 38-3b did not land");

	a_wr_land_3c: assert property (@(posedge clock) disable iff (!rst_b) // RULE_10
		wr_3c_3f |=> (map_r[7] == $past(reg_wdata)))
		else $error("write to codepoints 3c-3f did not land");

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Read and write together at one address must return the old byte
	a_rd_answer: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
		s_read_req |=> reg_rvld && (reg_rdata == $past(map_r[addr_idx])))
		else $error("read answer missing or wrong");

	a_rd_refused: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
		s_read_miss |=> !reg_rvld && (reg_rdata == DPMU_MAP_RST))
		else $error("read answer without in-range read");

	a_wr_refused: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
		s_wr_miss |=>
			$stable(map_r[0]) && $stable(map_r[1]) && $stable(map_r[2]) &&
			$stable(map_r[3]) && $stable(map_r[4]) && $stable(map_r[5]) &&
			$stable(map_r[6]) && $stable(map_r[7]))
		else $error("out-of-range write changed the table");

	a_table_hold: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
		!wr_hit |=>
			$stable(map_r[0]) && $stable(map_r[1]) && $stable(map_r[2]) &&
			$stable(map_r[3]) && $stable(map_r[4]) && $stable(map_r[5]) &&
			$stable(map_r[6]) && $stable(map_r[7]))
		else $error("table changed without a write");

	// ---------------------------------------------------------------
	// Lookup port
	// ---------------------------------------------------------------
	// Lower codepoints belong to another bank, so they must answer zero here
	a_cls_idle: assert property (@(posedge clock) disable iff (!rst_b) // RULE_11
		s_lookup_idle |=> !cls_prio_vld && !cls_hit && (cls_prio == DPMU_PRIO_RST))
		else $error("lookup answer without a request");

	a_cls_low: assert property (@(posedge clock) disable iff (!rst_b) // RULE_01
		s_lookup_low |=> cls_prio_vld && !cls_hit && (cls_prio == DPMU_PRIO_RST))
		else $error("low codepoint answered by this bank");

	a_cls_high: assert property (@(posedge clock) disable iff (!rst_b) // RULE_01
		s_lookup_high |=> cls_prio_vld && cls_hit)
		else $error("upper codepoint not answered");

	a_reset_all: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
		first_r |->
			(map_r[1] == DPMU_MAP_RST) && (map_r[2] == DPMU_MAP_RST) &&
			(map_r[4] == DPMU_MAP_RST) && (map_r[5] == DPMU_MAP_RST) &&
			(map_r[6] == DPMU_MAP_RST) && !reg_rvld && !cls_prio_vld &&
			!cls_hit && (cls_prio == DPMU_PRIO_RST))
		else $error("outputs or table not cleared by reset");

endmodule : dpmu_top
